// *** inc/clk_sel_pkg.sv ***
// constants, field layout and decode helpers of the main clock select block
`default_nettype none
package clk_sel_pkg;
   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_MAIN_CLOCK_MODE  = 16'hffa1;
   localparam logic [15:0] ADDR_HS_OSC_CONTROL   = 16'hffa2;
   localparam logic [15:0] ADDR_STAB_STATUS      = 16'hffa3;
   localparam logic [15:0] ADDR_STAB_WAIT_SELECT = 16'hffa4;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_MAIN_CLOCK_MODE   = 8'h00;
   localparam logic [7:0]  RST_HS_OSC_CONTROL    = 8'h80;
   localparam logic [7:0]  RST_STAB_STATUS       = 8'h00;
   localparam logic [7:0]  RST_STAB_WAIT_SELECT  = 8'h05;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int          STOP_BIT_POS          = 7;  // oscillator stop bit
   localparam int          PSRC_POS              = 2;  // peripheral source select
   localparam int          MCS_POS               = 1;  // main clock status
   localparam int          MSRC_POS              = 0;  // main source select
   localparam int          WAIT_W                = 3;  // wait select field width
   localparam int          STAGES                = 5;  // settle status bits
   localparam int          STAGE_W               = 3;  // stage index width
   localparam int          CNT_W                 = 17; // holds 2^16
   localparam logic [WAIT_W-1:0]  WAIT_CODE_MIN  = 3'h1;
   localparam logic [WAIT_W-1:0]  WAIT_CODE_MAX  = 3'h5;
   localparam logic [STAGE_W-1:0] STAGE_LAST     = 3'h4;
   // exponents of the settle thresholds, stage 0 is the shortest
   localparam logic [4:0][4:0] STAGE_EXP_DEF = {5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0b};

   // maps a wait code to its stage; prohibited codes fall on the longest
   function automatic logic [STAGE_W-1:0] wait_stage(input logic [WAIT_W-1:0] code);
      if (code >= WAIT_CODE_MIN && code <= WAIT_CODE_MAX) begin
         wait_stage = STAGE_W'(code - WAIT_CODE_MIN);
      end else begin
         wait_stage = STAGE_LAST;
      end
   endfunction

   // address compare shared by the read and the write path
   function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b);
      addr_hit = (a == b);
   endfunction
endpackage
`default_nettype wire

// *** inc/stab_if.sv ***
// carrier between the clock select top and its settle counter
`timescale 1ns/10ps
`default_nettype none
interface stab_if;
   logic                             run;       // oscillator enabled
   logic                             clear;     // restart counting
   logic                             tick;      // one x1 rising edge seen
   logic [clk_sel_pkg::STAGE_W-1:0]  stage_sel; // selected wait stage
   logic [clk_sel_pkg::STAGES-1:0]   status;    // sticky settle flags
   logic                             done;      // selected wait elapsed
   modport ctrl (output run, output clear, output tick, output stage_sel,
                 input status, input done);
   modport cnt  (input run, input clear, input tick, input stage_sel,
                 output status, output done);
endinterface
`default_nettype wire

// *** rtl/stab_counter.sv ***
// x1 oscillation settle counter with sticky stage flags
`timescale 1ns/10ps
`default_nettype none
module stab_counter
   import clk_sel_pkg::*;
#(
   parameter logic [4:0][4:0] STAGE_EXP = STAGE_EXP_DEF // threshold exponents
)(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   stab_if.cnt       sif
);
   import clk_sel_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0]  count;  // x1 edges since start
      logic [STAGES-1:0] status; // stage flags, bit 0 shortest
      logic              done;   // selected wait reached
   } cnt_state_t;
   localparam cnt_state_t CNT_RST = '{count: '0, status: '0, done: 1'b0};

   cnt_state_t st_ff;      // registered state
   cnt_state_t nxt_st;     // next state
   logic [CNT_W-1:0] thr_sel; // selected threshold

   // threshold of one stage
   function automatic logic [CNT_W-1:0] thr(input logic [STAGE_W-1:0] s);
      thr = CNT_W'(1) << STAGE_EXP[s];
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st  = st_ff;
      thr_sel = thr(sif.stage_sel);
      if (sif.clear || !sif.run) begin
         // time before the oscillator runs is never counted
         nxt_st = CNT_RST;
      end else if (sif.tick && st_ff.count < thr_sel) begin
         // saturates at the selected wait, so longer flags stay low
         nxt_st.count = st_ff.count + CNT_W'(1);
      end
      for (int i = 0; i < STAGES; i++) begin
         // flags rise in order and only ever set until cleared
         if (STAGE_W'(i) <= sif.stage_sel && nxt_st.count >= thr(STAGE_W'(i))) begin
            nxt_st.status[i] = 1'b1;
         end
      end
      nxt_st.done = (nxt_st.count >= thr_sel) && sif.run && !sif.clear;
   end

   // register the state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= CNT_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sif.status = st_ff.status;
   assign sif.done   = st_ff.done;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_clear_empties: assert property (sif.clear |=> (st_ff.count == '0 && st_ff.status == '0))
      else $error("settle state not emptied by clear");
   a_flags_sticky: assert property ((sif.run && !sif.clear) ##1 (sif.run && !sif.clear)
      |-> ((st_ff.status & $past(st_ff.status)) == $past(st_ff.status)))
      else $error("settle flag dropped while counting");
   a_count_capped: assert property (st_ff.count <= (CNT_W'(1) << STAGE_EXP[STAGE_LAST]))
      else $error("settle count beyond longest wait");
   a_no_tick_hold: assert property ((!sif.tick && !sif.clear && sif.run) |=> $stable(st_ff.count))
      else $error("count moved without an x1 edge");
   c_first_flag: cover property (st_ff.status[0] && !$past(st_ff.status[0]));
endmodule
`default_nettype wire

// *** rtl/main_clock_select.sv ***
// main clock source select, oscillator stop control and post-stop hold
// Notes on behaviour
// - stop bit halts or blocks the high-speed clock
// - reset clears main clock mode, internal selected
// - source and main select route both clocks
// - read-only main clock status at bit one
// - peripheral source select changes only once
// - dedicated peripheral clocks ignore clock selection
// - status cleared on reset, stop, stop bit
// - flags set in order and stay set
// - counting and flags limited to selected wait
// - wait codes one to five, reset five
// - cpu held after stop on the high-speed clock until wait elapsed
// - wait counted only once oscillation began
// - wait select accepts whole byte writes only
// - oscillator control resets with stop set
// - cpu clock status shows main or subsystem
`timescale 1ns/10ps
`default_nettype none
module main_clock_select
   import clk_sel_pkg::*;
#(
   parameter logic [4:0][4:0] STAGE_EXP = STAGE_EXP_DEF // shrink for simulation
)(
   input  wire  logic                clk_in,               // system clock
   input  wire  logic                rst_n_in,             // async reset, low
   input  wire  logic [15:0]         reg_addr_in,          // register address
   input  wire  logic [7:0]          reg_wdata_in,         // write data
   input  wire  logic                reg_wr_in,            // write strobe
   input  wire  logic                reg_bit_op_in,        // write is a bit op
   input  wire  logic                reg_rd_in,            // read strobe
   input  wire  logic                x1_clk_in,            // x1 clock pin
   input  wire  logic                stop_exec_in,         // stop executed
   input  wire  logic                stop_release_in,      // stop released
   input  wire  logic                cpu_on_subsystem_in,  // cpu on subsystem
   output logic [7:0]                reg_rdata_out,        // read data
   output logic                      osc_enable_out,       // run x1 / pass ext
   output logic                      main_clk_sel_out,     // 1 = high-speed
   output logic                      periph_clk_sel_out,   // 1 = high-speed
   output logic                      cpu_hold_out,         // cpu held
   output logic                      cpu_clock_status_out  // 1 = subsystem
);
   import clk_sel_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              sync1;       // pin synchroniser, first stage
      logic              sync2;       // pin synchroniser, second stage
      logic              x1_prev;     // edge detect history
      logic              stop_bit;    // oscillator stop bit
      logic              psrc;        // peripheral source select
      logic              psrc_locked; // one change already used
      logic              msrc;        // main source select
      logic              main_clock_status;         // main clock status
      logic [WAIT_W-1:0] wait_code;   // stabilization wait select
      logic              in_stop;     // stop mode active
      logic              hold;        // cpu held after stop
      logic              cpu_clock_status;         // cpu clock status
      logic              osc_en;      // registered oscillator enable
      logic              psel;        // registered peripheral select
      logic [7:0]        rdata;       // read data register
   } top_state_t;
   localparam top_state_t TOP_RST = '{
      sync1: 1'b0, sync2: 1'b0, x1_prev: 1'b0,
      stop_bit: RST_HS_OSC_CONTROL[STOP_BIT_POS],
      psrc: RST_MAIN_CLOCK_MODE[PSRC_POS], psrc_locked: 1'b0,
      msrc: RST_MAIN_CLOCK_MODE[MSRC_POS], main_clock_status: RST_MAIN_CLOCK_MODE[MCS_POS],
      wait_code: RST_STAB_WAIT_SELECT[WAIT_W-1:0],
      in_stop: 1'b0, hold: 1'b0, cpu_clock_status: 1'b0,
      osc_en: 1'b0, psel: 1'b0, rdata: 8'h00};

   top_state_t st_ff;               // registered state
   top_state_t nxt_st;              // next state
   logic [STAGES-1:0] status_reg;   // status in register bit order
   stab_if sif ();                  // link to the settle counter

   // ---------------------------------------------------------------
   // settle counter
   // ---------------------------------------------------------------
   stab_counter #(.STAGE_EXP(STAGE_EXP)) u_cnt (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .sif      (sif)
   );
   // counter runs only while the oscillator is enabled
   assign sif.run       = !st_ff.stop_bit && !st_ff.in_stop;
   // stop entry and the stop bit both restart the count
   assign sif.clear     = stop_exec_in || st_ff.stop_bit;
   // rising x1 edge seen after the synchroniser
   assign sif.tick      = st_ff.sync2 && !st_ff.x1_prev;
   assign sif.stage_sel = wait_stage(st_ff.wait_code);

   // longest stage sits at bit 0 of the status register
   always_comb begin
      for (int i = 0; i < STAGES; i++) begin
         status_reg[STAGES-1-i] = sif.status[i];
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st         = st_ff;
      // x1 is another domain: two flops before the edge detector
      nxt_st.sync1   = x1_clk_in;
      nxt_st.sync2   = st_ff.sync1;
      nxt_st.x1_prev = st_ff.sync2;
      nxt_st.cpu_clock_status     = cpu_on_subsystem_in;
      // register writes
      if (reg_wr_in) begin
         if (addr_hit(reg_addr_in, ADDR_HS_OSC_CONTROL)) begin
            nxt_st.stop_bit = reg_wdata_in[STOP_BIT_POS];
         end
         if (addr_hit(reg_addr_in, ADDR_MAIN_CLOCK_MODE)) begin
            nxt_st.msrc = reg_wdata_in[MSRC_POS];
            // one change only, so the peripheral clock cannot glitch twice
            if (!st_ff.psrc_locked && reg_wdata_in[PSRC_POS] != st_ff.psrc) begin
               nxt_st.psrc        = reg_wdata_in[PSRC_POS];
               nxt_st.psrc_locked = 1'b1;
            end
         end
         // bit operations on the wait select are dropped
         if (addr_hit(reg_addr_in, ADDR_STAB_WAIT_SELECT) && !reg_bit_op_in) begin
            nxt_st.wait_code = reg_wdata_in[WAIT_W-1:0];
         end
      end
      // main clock goes high-speed only with both selects set and clock on
      nxt_st.main_clock_status = nxt_st.psrc && nxt_st.msrc && !nxt_st.stop_bit;
      // stop mode sequencing
      if (stop_exec_in) begin
         nxt_st.in_stop = 1'b1;
      end else if (stop_release_in && st_ff.in_stop) begin
         nxt_st.in_stop = 1'b0;
         nxt_st.hold    = st_ff.main_clock_status; // hold only when x1 feeds the cpu
      end else if (st_ff.hold && sif.done) begin
         nxt_st.hold    = 1'b0; // end of hold from the settle counter
      end
      // pin-facing enables are flops, worked out from the next state,
      // so they change on the same edge as the bits behind them
      nxt_st.osc_en  = !nxt_st.stop_bit && !nxt_st.in_stop;
      nxt_st.psel    = nxt_st.psrc && !nxt_st.stop_bit;
      // read path, unmapped addresses answer zero
      if (reg_rd_in) begin
         if (addr_hit(reg_addr_in, ADDR_MAIN_CLOCK_MODE)) begin
            nxt_st.rdata = {5'h00, st_ff.psrc, st_ff.main_clock_status, st_ff.msrc};
         end else if (addr_hit(reg_addr_in, ADDR_HS_OSC_CONTROL)) begin
            nxt_st.rdata = {st_ff.stop_bit, 7'h00};
         end else if (addr_hit(reg_addr_in, ADDR_STAB_STATUS)) begin
            nxt_st.rdata = {3'h0, status_reg}; // upper bits read zero
         end else if (addr_hit(reg_addr_in, ADDR_STAB_WAIT_SELECT)) begin
            nxt_st.rdata = {5'h00, st_ff.wait_code};
         end else begin
            nxt_st.rdata = 8'h00;
         end
      end
   end

   // register the state; reset values are constants only
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff <= TOP_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_out        = st_ff.rdata;
   // stop bit or stop mode halts the oscillator or blocks the pin
   assign osc_enable_out       = st_ff.osc_en;
   assign main_clk_sel_out     = st_ff.main_clock_status;
   // only the general peripheral clock follows the select;
   // watchdog and own-clock peripherals are wired elsewhere
   assign periph_clk_sel_out   = st_ff.psel;
   assign cpu_hold_out         = st_ff.hold;
   assign cpu_clock_status_out = st_ff.cpu_clock_status;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_stop_blocks_osc: assert property ((st_ff.stop_bit || st_ff.in_stop) |-> !osc_enable_out)
      else $error("oscillator enabled with stop bit set");
   a_psrc_once: assert property ((st_ff.psrc_locked && reg_wr_in) |=> $stable(st_ff.psrc))
      else $error("peripheral select changed twice");
   a_mcs_needs_both: assert property (main_clk_sel_out |-> (st_ff.psrc && st_ff.msrc))
      else $error("main clock high-speed without both selects");
   a_bitop_ignored: assert property ((reg_wr_in && reg_bit_op_in
      && reg_addr_in == ADDR_STAB_WAIT_SELECT) |=> $stable(st_ff.wait_code))
      else $error("bit op changed wait select");
   a_stop_clears_flags: assert property (stop_exec_in |=> ##1 (status_reg == '0))
      else $error("status not cleared after stop entry");
   a_hold_on_release: assert property ((stop_release_in && st_ff.in_stop && st_ff.main_clock_status
      && !stop_exec_in) |=> cpu_hold_out)
      else $error("cpu not held after stop release");
   a_hold_ends: assert property ((cpu_hold_out && sif.done && !stop_exec_in
      && !stop_release_in) |=> !cpu_hold_out)
      else $error("hold outlived the selected wait");
   // only the rise is judged: a later change of wait code leaves set flags alone
   a_flags_in_range: assert property ($rose(sif.status[STAGES-1]) |-> ($past(sif.stage_sel) == STAGE_LAST))
      else $error("status beyond selected wait");
   c_psrc_switch: cover property (st_ff.psrc && !$past(st_ff.psrc));
   c_hold_done: cover property (cpu_hold_out ##1 !cpu_hold_out);
   c_osc_start: cover property (!osc_enable_out ##1 osc_enable_out);
endmodule
`default_nettype wire

// *** dv/x1_osc_model.sv ***
// behavioural model of the x1 crystal or external clock source
`timescale 1ns/10ps
`default_nettype none
module x1_osc_model #(
   parameter int HALF_NS  = 20,  // half period, well below the system clock rate
   parameter int START_NS = 100  // dead time before oscillation builds up
)(
   input  wire logic enable_in,  // run x1 / pass the external clock
   output var  logic x1_clk_out  // clock seen at the x1 pin
);
   // ---------------------------------------------------------------
   // oscillator
   // ---------------------------------------------------------------
   // no edges during the start-up dead time, so none may be counted
   initial begin
      x1_clk_out = 1'b0;
      forever begin
         wait (enable_in === 1'b1);
         #(START_NS);
         while (enable_in === 1'b1) begin
            #(HALF_NS) x1_clk_out = ~x1_clk_out;
         end
         x1_clk_out = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** dv/main_clock_select_bench.sv ***
// self-checking bench of the main clock select block
`timescale 1ns/10ps
`default_nettype none
module main_clock_select_bench;
   import clk_sel_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic        clk_in;              // 250 mhz system clock
   logic        rst_n_in;            // async reset, low
   logic [15:0] reg_addr_in;         // register address
   logic [7:0]  reg_wdata_in;        // write data
   logic        reg_wr_in;           // write strobe
   logic        reg_bit_op_in;       // bit manipulation flag
   logic        reg_rd_in;           // read strobe
   logic        x1_clk;              // from the oscillator model
   logic        stop_exec_in;        // stop executed pulse
   logic        stop_release_in;     // stop released pulse
   logic        cpu_on_subsystem_in; // cpu on subsystem clock
   logic [7:0]  reg_rdata_out;       // read data
   logic        osc_enable_out;      // oscillator runs
   logic        main_clk_sel_out;    // main clock on high-speed
   logic        periph_clk_sel_out;  // peripheral clock on high-speed
   logic        cpu_hold_out;        // cpu held after stop
   logic        cpu_clock_status_out;// subsystem status
   int          miscompares = 0;     // mismatches seen
   int          checked = 0;         // comparisons made
   int unsigned x1_seen = 0;         // x1 rising edges so far
   int unsigned start_cnt;           // edge count at stop release
   // ---------------------------------------------------------------
   // design and partner
   // ---------------------------------------------------------------
   // thresholds shrunk to 8..128 edges to keep the run short
   main_clock_select #(
      .STAGE_EXP ({5'h07, 5'h06, 5'h05, 5'h04, 5'h03})
   ) u_main_clock_select (
      .clk_in               (clk_in),
      .rst_n_in             (rst_n_in),
      .reg_addr_in          (reg_addr_in),
      .reg_wdata_in         (reg_wdata_in),
      .reg_wr_in            (reg_wr_in),
      .reg_bit_op_in        (reg_bit_op_in),
      .reg_rd_in            (reg_rd_in),
      .x1_clk_in            (x1_clk),
      .stop_exec_in         (stop_exec_in),
      .stop_release_in      (stop_release_in),
      .cpu_on_subsystem_in  (cpu_on_subsystem_in),
      .reg_rdata_out        (reg_rdata_out),
      .osc_enable_out       (osc_enable_out),
      .main_clk_sel_out     (main_clk_sel_out),
      .periph_clk_sel_out   (periph_clk_sel_out),
      .cpu_hold_out         (cpu_hold_out),
      .cpu_clock_status_out (cpu_clock_status_out)
   );
   x1_osc_model u_x1_osc_model (
      .enable_in  (osc_enable_out),
      .x1_clk_out (x1_clk)
   );
   // ---------------------------------------------------------------
   // clock, edge count, watchdog
   // ---------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   always @(posedge x1_clk) x1_seen <= x1_seen + 1;
   // the tests need about 14k cycles; allow about three and a half times that
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic conclude();
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask
   // one-cycle write strobe, bit_op marks a bit manipulation
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bit_op);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_bit_op_in = bit_op;
      reg_wr_in = 1'b1;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
      reg_bit_op_in = 1'b0;
   endtask
   // read data holds until the next strobe, so a late look is safe
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      @(negedge clk_in);
      chk(what, exp, reg_rdata_out);
   endtask
   // n x1 edges, then room for the synchroniser
   task automatic x1_wait(input int n);
      repeat (n) @(posedge x1_clk);
      repeat (6) @(negedge clk_in);
   endtask
   // one-cycle pulse: stop entry when rel is 0, stop release when 1
   task automatic pulse(input logic rel);
      @(negedge clk_in);
      if (rel) begin
         stop_release_in = 1'b1;
      end else begin
         stop_exec_in = 1'b1;
      end
      @(negedge clk_in);
      stop_exec_in = 1'b0;
      stop_release_in = 1'b0;
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      rst_n_in = 1'b0;
      reg_addr_in = 16'h0000;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_bit_op_in = 1'b0;
      reg_rd_in = 1'b0;
      stop_exec_in = 1'b0;
      stop_release_in = 1'b0;
      cpu_on_subsystem_in = 1'b0;
      repeat (20) @(negedge clk_in);
      rst_n_in = 1'b1;
      chk("osc_enable", 8'h00, {7'h00, osc_enable_out});
      rd_chk("mode", ADDR_MAIN_CLOCK_MODE, 8'h00);
      rd_chk("osc_ctrl", ADDR_HS_OSC_CONTROL, 8'h80);
      rd_chk("status", ADDR_STAB_STATUS, 8'h00);
      rd_chk("wait_sel", ADDR_STAB_WAIT_SELECT, 8'h05);
      rd_chk("unmapped", 16'hffa5, 8'h00);
      wr(ADDR_STAB_WAIT_SELECT, 8'h01, 1'b1);
      rd_chk("wait_bitop", ADDR_STAB_WAIT_SELECT, 8'h05);
      wr(ADDR_STAB_STATUS, 8'hff, 1'b0);
      rd_chk("status_ro", ADDR_STAB_STATUS, 8'h00);
      // start the oscillator, watch the flags fill in order
      wr(ADDR_HS_OSC_CONTROL, 8'h00, 1'b0);
      chk("osc_run", 8'h01, {7'h00, osc_enable_out});
      x1_wait(12);
      rd_chk("status_2k", ADDR_STAB_STATUS, 8'h10);
      x1_wait(12);
      rd_chk("status_8k", ADDR_STAB_STATUS, 8'h18);
      // each wait code from one to five limits the flags that may come up
      for (int c = 1; c <= 5; c++) begin
         wr(ADDR_HS_OSC_CONTROL, 8'h80, 1'b0);
         rd_chk("status_clr", ADDR_STAB_STATUS, 8'h00);
         wr(ADDR_STAB_WAIT_SELECT, 8'(c), 1'b0);
         wr(ADDR_HS_OSC_CONTROL, 8'h00, 1'b0);
         x1_wait(200);
         rd_chk("status_lim", ADDR_STAB_STATUS, 8'h1f & (8'h1f << (5 - c)));
      end
      // clock routing and the one-time peripheral source change
      wr(ADDR_MAIN_CLOCK_MODE, 8'h05, 1'b0);
      rd_chk("mode_hs", ADDR_MAIN_CLOCK_MODE, 8'h07);
      chk("main_sel", 8'h01, {7'h00, main_clk_sel_out});
      chk("periph_sel", 8'h01, {7'h00, periph_clk_sel_out});
      wr(ADDR_MAIN_CLOCK_MODE, 8'h01, 1'b0);
      rd_chk("psrc_once", ADDR_MAIN_CLOCK_MODE, 8'h07);
      wr(ADDR_MAIN_CLOCK_MODE, 8'h06, 1'b0);
      rd_chk("mcs_ro", ADDR_MAIN_CLOCK_MODE, 8'h04);
      chk("main_int", 8'h00, {7'h00, main_clk_sel_out});
      wr(ADDR_MAIN_CLOCK_MODE, 8'h05, 1'b0);
      cpu_on_subsystem_in = 1'b1;
      repeat (2) @(negedge clk_in);
      chk("cls", 8'h01, {7'h00, cpu_clock_status_out});
      cpu_on_subsystem_in = 1'b0;
      // stop with the cpu on x1: held until the wait has run
      pulse(1'b0);
      repeat (2) @(negedge clk_in);
      chk("osc_in_stop", 8'h00, {7'h00, osc_enable_out});
      rd_chk("status_stop", ADDR_STAB_STATUS, 8'h00);
      pulse(1'b1);
      start_cnt = x1_seen;
      repeat (2) @(negedge clk_in);
      chk("hold_on", 8'h01, {7'h00, cpu_hold_out});
      for (int i = 0; i < 3000 && cpu_hold_out === 1'b1; i++) @(negedge clk_in);
      chk("hold_end", 8'h01, {7'h00, cpu_hold_out === 1'b0 && (x1_seen - start_cnt) inside {[128:129]}});
      // stop bit set only with the cpu back on the internal clock
      wr(ADDR_MAIN_CLOCK_MODE, 8'h04, 1'b0);
      // stop on the internal clock: no hold, software polls the status
      pulse(1'b0);
      pulse(1'b1);
      chk("hold_int", 8'h00, {7'h00, cpu_hold_out});
      x1_wait(200);
      rd_chk("status_poll", ADDR_STAB_STATUS, 8'h1f);
      wr(ADDR_HS_OSC_CONTROL, 8'h80, 1'b0);
      chk("osc_off", 8'h00, {7'h00, osc_enable_out});
      chk("periph_off", 8'h00, {7'h00, periph_clk_sel_out});
      rd_chk("status_msb", ADDR_STAB_STATUS, 8'h00);
      rd_chk("osc_ctrl_rb", ADDR_HS_OSC_CONTROL, 8'h80);
      conclude();
   end
endmodule
`default_nettype wire
